// File: common/hbg_pkg.sv
/*
 Shared constants and types of the half-bridge gate control block.
 Assumes a 10 MHz pclk and a 32-bit APB slave with byte addresses.
*/
package hbg_pkg;
	// Clock
	localparam int CLK_PERIOD_NS = 100;

	// APB map
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_DRIVE = 12'h004;
	localparam logic [11:0] ADDR_TIMING = 12'h008;
	localparam logic [11:0] ADDR_STATUS = 12'h00C;

	// Control register fields
	localparam int CTRL_SRC_SEL_BIT = 0;
	localparam int CTRL_PWM_LVL_BIT = 1;
	localparam int CTRL_HIZ_BIT = 2;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	// Drive register fields
	localparam int CUR_W = 4;
	localparam int DRV_SRC_LSB = 0;
	localparam int DRV_SINK_LSB = 4;
	localparam logic [31:0] DRIVE_RST = 32'h0000_0077;

	// Timing register fields, counts in pclk cycles
	localparam int TIM_W = 8;
	localparam int TIM_DRIVE_LSB = 0;
	localparam int TIM_DEAD_LSB = 8;
	localparam logic [31:0] TIMING_RST = 32'h0000_0404;

	// Status register fields
	localparam int ST_HIGH_BIT = 0;
	localparam int ST_LOW_BIT = 1;
	localparam int ST_HIZ_BIT = 2;
	localparam int ST_SLEEP_BIT = 3;
	localparam int ST_HW_BIT = 4;
	localparam int ST_BLANK_BIT = 5;
	localparam int ST_STATE_LSB = 8;

	// Hardware-variant configuration code width
	localparam int CFG_W = 4;

	// Gate sequence states
	typedef enum logic [2:0] {
		HBG_S_HIZ = 3'b000,
		HBG_S_DEAD = 3'b001,
		HBG_S_DRV_HS = 3'b010,
		HBG_S_HOLD_HS = 3'b011,
		HBG_S_DRV_LS = 3'b100,
		HBG_S_HOLD_LS = 3'b101
	} hbg_state_t;

	// Current stage applied to one gate
	typedef enum logic [1:0] {
		HBG_G_STRONG = 2'b00,
		HBG_G_SINK = 2'b01,
		HBG_G_SOURCE = 2'b10,
		HBG_G_HOLD = 2'b11
	} hbg_gmode_t;
endpackage

// File: hdl/hbg_sync.sv
/*
 Two-flop synchroniser for a group of independent level inputs.
 Assumes each bit is a slow level; reset value chosen by parameter.
*/
`timescale 1ns/10ps
module hbg_sync import hbg_pkg::*; #(
	parameter int W = 3,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, low
	input wire logic [W-1:0] d, // Raw inputs
	output logic [W-1:0] q // Synchronised levels
);
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic meta_q;
			// First flop feeds only the second
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					meta_q <= RST[i];
					q[i] <= RST[i];
				end
				else
				begin
					meta_q <= d[i];
					q[i] <= meta_q;
				end
			end
		end
	endgenerate
endmodule

// File: hdl/hbg_apb.sv
/*
 APB register file of the half-bridge gate control block.
 Assumes an APB master per the protocol; answers with zero wait states.
*/
`timescale 1ns/10ps
module hbg_apb import hbg_pkg::*; (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, low
	input wire logic [11:0] paddr, // Byte address
	input wire logic psel, // Select
	input wire logic penable, // Access phase
	input wire logic pwrite, // Write
	input wire logic [31:0] pwdata, // Write data
	output logic [31:0] prdata, // Read data
	output logic pready, // Ready
	output logic pslverr, // Error
	input wire logic wr_allow, // Serial writes accepted
	input wire logic [31:0] status_in, // Live status word
	output logic pwm_source_select, // Register drives PWM
	output logic reg_pwm_level, // Register PWM level
	output logic reg_hiz_request, // Register high-Z request
	output logic [3:0] source_current_field, // Peak source code
	output logic [3:0] sink_current_field, // Peak sink code
	output logic [7:0] drive_interval_field, // Drive interval
	output logic [7:0] dead_interval_field // Dead interval
);
	logic [31:0] ctrl_q;
	logic [31:0] drive_q;
	logic [31:0] timing_q;
	logic hit_rw;
	logic hit_any;
	logic wr_ok;

	// Address decode
	assign hit_rw = paddr == ADDR_CTRL || paddr == ADDR_DRIVE || paddr == ADDR_TIMING;
	assign hit_any = hit_rw || paddr == ADDR_STATUS;
	assign wr_ok = hit_rw && wr_allow;
	assign pready = 1'b1;
	// Error on unmapped address or refused write
	assign pslverr = psel && penable && (!hit_any || (pwrite && !wr_ok));

	// Register writes take effect in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= CTRL_RST;
			drive_q <= DRIVE_RST;
			timing_q <= TIMING_RST;
		end
		else if (psel && penable && pwrite && wr_ok)
		begin
			if (paddr == ADDR_CTRL)
				ctrl_q <= pwdata & 32'h0000_0007;
			if (paddr == ADDR_DRIVE)
				drive_q <= pwdata & 32'h0000_00FF;
			if (paddr == ADDR_TIMING)
				timing_q <= pwdata & 32'h0000_FFFF;
		end
	end

	// Read data captured in the setup phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
		begin
			unique case (paddr)
				ADDR_CTRL: prdata <= ctrl_q;
				ADDR_DRIVE: prdata <= drive_q;
				ADDR_TIMING: prdata <= timing_q;
				ADDR_STATUS: prdata <= status_in;
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Field taps
	assign pwm_source_select = ctrl_q[CTRL_SRC_SEL_BIT];
	assign reg_pwm_level = ctrl_q[CTRL_PWM_LVL_BIT];
	assign reg_hiz_request = ctrl_q[CTRL_HIZ_BIT];
	assign source_current_field = drive_q[DRV_SRC_LSB +: CUR_W];
	assign sink_current_field = drive_q[DRV_SINK_LSB +: CUR_W];
	assign drive_interval_field = timing_q[TIM_DRIVE_LSB +: TIM_W];
	assign dead_interval_field = timing_q[TIM_DEAD_LSB +: TIM_W];
endmodule

// File: hdl/hbg_gate_ctrl.sv
/*
 Top of the half-bridge gate control: input selection, configuration
 latching, gate sequencing and APB registers.
 Assumes pins are synchronous-ish levels; analog stages sit outside.
*/
// The APB register port and the register addresses were chosen for this implementation.
// What this block does
// - Hi-Z request low holds both gates off with the strong pull-down; else PWM 0 low side, 1 high side.
// - Hi-Z request overrides PWM; PWM ignored while it is active.
// - Dead time is inserted internally so one PWM input drives both gates.
// - On serial variant a select bit lets a register level replace the PWM pin.
// - On serial variant Hi-Z is pin request OR register request.
// - Hardware variant reads the four serial pins as configuration inputs.
// - Hardware configuration is latched at power-up, later pin changes ignored until a wake.
// - Sleep then wake re-latches the hardware configuration.
// - Peak drive current is applied for the programmed drive interval per transition.
// - Gate and drain fault monitors are blanked during the drive interval.
// - An on gate is held with the hold pull-up current after switching.
// - An off gate is kept discharged with the strong pull-down after switching.
// - Peak source and sink codes are chosen independently by register; hardware variant uses one pin code for both.
// - The dead interval comes from a register field.
// - Current codes are 4 bits, 16 monotonic steps.
// - A new PWM command ends the drive interval at once.
// - Strong pull-down holds a gate while the opposite gate switches.
`timescale 1ns/10ps
module hbg_gate_ctrl import hbg_pkg::*; (
	input wire logic pclk, // Clock, 10 MHz
	input wire logic presetn, // Async reset, low
	input wire logic [11:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic hw_variant, // Strap: 1 hardware variant
	input wire logic halfbridge_pwm_input, // PWM pin
	input wire logic hiz_request_n_pin, // High-Z request, low
	input wire logic sleep_n_pin, // Sleep request, low
	input wire logic serial_select_n, // Serial select, low
	input wire logic [3:0] gain_pin, // Amplifier gain setting
	input wire logic [3:0] overcurrent_threshold_pin, // Overcurrent level
	input wire logic [3:0] gate_current_setting, // Gate current strength
	input wire logic [3:0] mode_pin, // Operating mode setting
	output logic high_gate_out, // High gate on
	output logic low_gate_out, // Low gate on
	output hbg_gmode_t high_gate_mode, // High gate current stage
	output hbg_gmode_t low_gate_mode, // Low gate current stage
	output logic [3:0] source_current_code, // Peak source code
	output logic [3:0] sink_current_code, // Peak sink code
	output logic fault_blank, // Fault monitors blanked
	output logic [3:0] gain_code, // Latched gain
	output logic [3:0] ocp_level_code, // Latched overcurrent level
	output logic [3:0] mode_code, // Latched mode
	output logic hw_active // Latched variant
);
	logic pwm_s;
	logic hiz_n_s;
	logic sleep_s;
	logic sleep_prev_q;
	logic init_q;
	logic latch_ev;
	logic hw_q;
	logic [3:0] cur_pin_q;
	logic src_sel;
	logic reg_lvl;
	logic reg_hiz;
	logic [3:0] src_field;
	logic [3:0] sink_field;
	logic [7:0] drv_field;
	logic [7:0] dead_field;
	logic pwm_eff;
	logic hiz_request;
	logic halt;
	hbg_state_t state_q;
	logic [7:0] timer_q;
	logic last_hs_q;
	logic [31:0] status;

	// Pin levels into the clock domain; reset reads awake so no false wake edge
	hbg_sync #(.W(3), .RST(3'b001)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({halfbridge_pwm_input, hiz_request_n_pin, sleep_n_pin}),
		.q({pwm_s, hiz_n_s, sleep_s})
	);

	// Register file
	hbg_apb u_apb (
		.pclk(pclk),
		.presetn(presetn),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.wr_allow(!serial_select_n && !hw_q),
		.status_in(status),
		.pwm_source_select(src_sel),
		.reg_pwm_level(reg_lvl),
		.reg_hiz_request(reg_hiz),
		.source_current_field(src_field),
		.sink_current_field(sink_field),
		.drive_interval_field(drv_field),
		.dead_interval_field(dead_field)
	);

	// Latch at first cycle after reset and on every wake
	assign latch_ev = !init_q || (sleep_s && !sleep_prev_q);

	// Wake edge tracking
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			init_q <= 1'b0;
			sleep_prev_q <= 1'b1;
		end
		else
		begin
			init_q <= 1'b1;
			sleep_prev_q <= sleep_s;
		end
	end

	// Hardware configuration latch, pins ignored between events
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hw_q <= 1'b0;
			gain_code <= 4'h0;
			ocp_level_code <= 4'h0;
			cur_pin_q <= 4'h0;
			mode_code <= 4'h0;
		end
		else if (latch_ev)
		begin
			hw_q <= hw_variant;
			gain_code <= gain_pin;
			ocp_level_code <= overcurrent_threshold_pin;
			cur_pin_q <= gate_current_setting;
			mode_code <= mode_pin;
		end
	end
	assign hw_active = hw_q;

	// Effective commands
	assign pwm_eff = (!hw_q && src_sel) ? reg_lvl : pwm_s;
	assign hiz_request = !hiz_n_s || (!hw_q && reg_hiz);
	assign halt = hiz_request || !sleep_s;

	// Peak current codes, 16 steps each, picked per variant
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			source_current_code <= 4'h0;
			sink_current_code <= 4'h0;
		end
		else
		begin
			source_current_code <= hw_q ? cur_pin_q : src_field;
			sink_current_code <= hw_q ? cur_pin_q : sink_field;
		end
	end

	// Gate sequence: break, dead interval, then make with peak drive
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= HBG_S_HIZ;
			timer_q <= 8'h00;
			last_hs_q <= 1'b0;
		end
		else if (halt)
		begin
			state_q <= HBG_S_HIZ;
			timer_q <= 8'h00;
		end
		else
		begin
			unique case (state_q)
				HBG_S_HIZ:
				begin
					state_q <= HBG_S_DEAD;
					timer_q <= dead_field;
				end
				HBG_S_DEAD:
				begin
					if (timer_q == 8'h00)
					begin
						state_q <= pwm_eff ? HBG_S_DRV_HS : HBG_S_DRV_LS;
						timer_q <= drv_field;
					end
					else
						timer_q <= timer_q - 8'h01;
				end
				HBG_S_DRV_HS, HBG_S_HOLD_HS:
				begin
					if (!pwm_eff)
					begin
						state_q <= HBG_S_DEAD;
						timer_q <= dead_field;
						last_hs_q <= 1'b1;
					end
					else if (state_q == HBG_S_DRV_HS && timer_q == 8'h00)
						state_q <= HBG_S_HOLD_HS;
					else if (state_q == HBG_S_DRV_HS)
						timer_q <= timer_q - 8'h01;
				end
				HBG_S_DRV_LS, HBG_S_HOLD_LS:
				begin
					if (pwm_eff)
					begin
						state_q <= HBG_S_DEAD;
						timer_q <= dead_field;
						last_hs_q <= 1'b0;
					end
					else if (state_q == HBG_S_DRV_LS && timer_q == 8'h00)
						state_q <= HBG_S_HOLD_LS;
					else if (state_q == HBG_S_DRV_LS)
						timer_q <= timer_q - 8'h01;
				end
				default:
					state_q <= HBG_S_HIZ;
			endcase
		end
	end

	// Gate levels and current stages decoded from the sequence state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			high_gate_out <= 1'b0;
			low_gate_out <= 1'b0;
			high_gate_mode <= HBG_G_STRONG;
			low_gate_mode <= HBG_G_STRONG;
			fault_blank <= 1'b0;
		end
		else
		begin
			high_gate_out <= state_q == HBG_S_DRV_HS || state_q == HBG_S_HOLD_HS;
			low_gate_out <= state_q == HBG_S_DRV_LS || state_q == HBG_S_HOLD_LS;
			fault_blank <= state_q == HBG_S_DRV_HS || state_q == HBG_S_DRV_LS;
			high_gate_mode <= HBG_G_STRONG;
			low_gate_mode <= HBG_G_STRONG;
			unique case (state_q)
				HBG_S_DRV_HS: high_gate_mode <= HBG_G_SOURCE;
				HBG_S_HOLD_HS: high_gate_mode <= HBG_G_HOLD;
				HBG_S_DRV_LS: low_gate_mode <= HBG_G_SOURCE;
				HBG_S_HOLD_LS: low_gate_mode <= HBG_G_HOLD;
				HBG_S_DEAD:
				begin
					if (last_hs_q)
						high_gate_mode <= HBG_G_SINK;
					else
						low_gate_mode <= HBG_G_SINK;
				end
				default:
				begin
				end
			endcase
		end
	end

	// Status word for software
	always_comb
	begin
		status = 32'h0000_0000;
		status[ST_HIGH_BIT] = high_gate_out;
		status[ST_LOW_BIT] = low_gate_out;
		status[ST_HIZ_BIT] = hiz_request;
		status[ST_SLEEP_BIT] = !sleep_s;
		status[ST_HW_BIT] = hw_q;
		status[ST_BLANK_BIT] = fault_blank;
		status[ST_STATE_LSB +: 3] = state_q;
	end

	// Checks
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_hiz_off;
		hiz_request |-> ##2 (!high_gate_out && !low_gate_out);
	endproperty
	a_hiz_off: assert property (p_hiz_off) else $error("gate on under hi-z");

	property p_no_overlap;
		!(high_gate_out && low_gate_out);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("both gates on");

	property p_dead_gap;
		$fell(high_gate_out) |-> !low_gate_out ##1 !low_gate_out;
	endproperty
	a_dead_gap: assert property (p_dead_gap) else $error("no dead gap");

	property p_reg_pwm;
		(!halt && !hw_q && src_sel && !reg_lvl && state_q == HBG_S_HOLD_HS)
			|=> state_q == HBG_S_DEAD;
	endproperty
	a_reg_pwm: assert property (p_reg_pwm) else $error("register pwm ignored");

	property p_reg_hiz;
		(!hw_q && reg_hiz) |=> state_q == HBG_S_HIZ;
	endproperty
	a_reg_hiz: assert property (p_reg_hiz) else $error("register hi-z ignored");

	property p_blank;
		(state_q == HBG_S_DRV_HS) |=> fault_blank;
	endproperty
	a_blank: assert property (p_blank) else $error("monitor not blanked");

	property p_drive_end;
		(!halt && state_q == HBG_S_DRV_HS && !pwm_eff) |=> state_q == HBG_S_DEAD;
	endproperty
	a_drive_end: assert property (p_drive_end) else $error("drive not cut short");

	property p_hold;
		(state_q == HBG_S_HOLD_HS) |=> high_gate_mode == HBG_G_HOLD;
	endproperty
	a_hold: assert property (p_hold) else $error("no hold current");

	property p_strong;
		(state_q == HBG_S_DRV_LS) |=> high_gate_mode == HBG_G_STRONG;
	endproperty
	a_strong: assert property (p_strong) else $error("no strong pulldown");

	property p_latch;
		!latch_ev |=> $stable(gain_code) && $stable(hw_q);
	endproperty
	a_latch: assert property (p_latch) else $error("config moved");

	c_hs_hold: cover property (state_q == HBG_S_DRV_HS ##[1:300] state_q == HBG_S_HOLD_HS);
	c_switch: cover property ($fell(high_gate_out) ##[1:300] low_gate_out);
	c_wake: cover property (sleep_s && !sleep_prev_q);
endmodule

// File: bench/hbg_mcu_model.sv
/*
 Controller model on the far side of the gate control block: drives the
 PWM, high-Z, sleep, serial select and hardware configuration pins.
 Assumes the bench calls its tasks; every change lands just after a pclk edge.
*/
`timescale 1ns/10ps
module hbg_mcu_model (
	input wire logic pclk, // Clock, from the bench
	output logic halfbridge_pwm_input, // PWM pin level
	output logic hiz_request_n_pin, // High-Z request, low
	output logic sleep_n_pin, // Sleep request, low
	output logic serial_select_n, // Serial select, low
	output logic [15:0] cfg_pins // Gain, threshold, strength, mode
);

	// Idle pin levels: running, not selected, no high-Z
	initial
	begin
		halfbridge_pwm_input = 1'b0;
		hiz_request_n_pin = 1'b1;
		sleep_n_pin = 1'b1;
		serial_select_n = 1'b1;
		cfg_pins = 16'h0000;
	end

	// PWM pin level
	task set_pwm(input logic v);
		@(posedge pclk);
		halfbridge_pwm_input <= v;
	endtask

	// High-Z request, active low on the pin
	task set_hiz(input logic req);
		@(posedge pclk);
		hiz_request_n_pin <= ~req;
	endtask

	// Select held low over a whole exchange
	task select(input logic s);
		@(posedge pclk);
		serial_select_n <= ~s;
	endtask

	// Hardware configuration pins
	task set_cfg(input logic [15:0] c);
		@(posedge pclk);
		cfg_pins <= c;
	endtask

	// Sleep, alter the pins, then wake so the block latches them again
	task reconfigure(input logic [15:0] c);
		@(posedge pclk);
		sleep_n_pin <= 1'b0;
		repeat (4) @(posedge pclk);
		set_cfg(c);
		repeat (4) @(posedge pclk);
		sleep_n_pin <= 1'b1;
	endtask
endmodule

// File: bench/half_bridge_gate_control_bench.sv
/*
 Self-checking bench of the half-bridge gate control block.
 Assumes hbg_pkg, a 10 MHz pclk and the controller model beside it.
*/
`timescale 1ns/10ps
module half_bridge_gate_control_bench import hbg_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, hw_variant;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic high_gate_out, low_gate_out, fault_blank, hw_active;
	hbg_gmode_t high_gate_mode, low_gate_mode;
	logic [3:0] source_current_code, sink_current_code, gain_code, ocp_level_code, mode_code;
	logic halfbridge_pwm_input, hiz_request_n_pin, sleep_n_pin, serial_select_n;
	logic [15:0] cfg_pins;
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;
	int n;

	hbg_mcu_model mcu_i (
		.pclk(pclk),
		.halfbridge_pwm_input(halfbridge_pwm_input),
		.hiz_request_n_pin(hiz_request_n_pin),
		.sleep_n_pin(sleep_n_pin),
		.serial_select_n(serial_select_n),
		.cfg_pins(cfg_pins)
	);

	hbg_gate_ctrl hbg_gate_ctrl_i (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hw_variant(hw_variant),
		.halfbridge_pwm_input(halfbridge_pwm_input),
		.hiz_request_n_pin(hiz_request_n_pin), .sleep_n_pin(sleep_n_pin),
		.serial_select_n(serial_select_n), .gain_pin(cfg_pins[15:12]),
		.overcurrent_threshold_pin(cfg_pins[11:8]),
		.gate_current_setting(cfg_pins[7:4]), .mode_pin(cfg_pins[3:0]),
		.high_gate_out(high_gate_out), .low_gate_out(low_gate_out),
		.high_gate_mode(high_gate_mode), .low_gate_mode(low_gate_mode),
		.source_current_code(source_current_code), .sink_current_code(sink_current_code),
		.fault_blank(fault_blank), .gain_code(gain_code), .ocp_level_code(ocp_level_code),
		.mode_code(mode_code), .hw_active(hw_active)
	);

	// Clock, shared with the controller model
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// Verdict and end of run
	task give_verdict;
		$display("comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Hang guard
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fails = fails + 1;
			give_verdict();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// No bound of its own; pready seen high ends this wait, else the hang guard
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Waits, bounded, for a pair of gate levels, then compares them
	task wait_gate(input logic hi, input logic lo);
		n = 0;
		while (!(high_gate_out === hi && low_gate_out === lo) && n < 60)
		begin
			@(negedge pclk);
			n++;
		end
		chk({high_gate_out, low_gate_out}, {hi, lo});
	endtask

	// Main sequence
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		hw_variant = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, ADDR_CTRL, 32'h0000_0000);
		chk(rd, CTRL_RST);
		apb(0, ADDR_DRIVE, 32'h0000_0000);
		chk(rd, DRIVE_RST);
		apb(0, ADDR_TIMING, 32'h0000_0000);
		chk(rd, TIMING_RST);
		apb(0, 12'h0F0, 32'h0000_0000);
		chk(err, 1);
		chk(rd, 32'h0000_0000);
		wait_gate(0, 1);
		apb(0, ADDR_STATUS, 32'h0000_0000);
		chk(rd & 32'h0000_0703, 32'h0000_0502);
		mcu_i.select(1);
		apb(1, ADDR_DRIVE, 32'h0000_005A);
		// Register lands at the access edge, the code flops one edge later
		repeat (2) @(negedge pclk);
		chk({sink_current_code, source_current_code}, 32'h0000_005A);
		apb(1, ADDR_TIMING, 32'h0000_0203);
		// Low to high: dead span, then drive span with blanking
		mcu_i.set_pwm(1);
		wait_gate(0, 0);
		n = 0;
		while (high_gate_out !== 1'b1 && n < 60)
		begin
			@(negedge pclk);
			n++;
		end
		chk(n, 3);
		n = 0;
		while (fault_blank !== 1'b1 && n < 10)
		begin
			@(negedge pclk);
			n++;
		end
		n = 0;
		while (fault_blank === 1'b1 && n < 60)
		begin
			if (n == 1)
				chk({high_gate_mode, low_gate_mode}, {HBG_G_SOURCE, HBG_G_STRONG});
			@(negedge pclk);
			n++;
		end
		chk(n, 4);
		repeat (2) @(negedge pclk);
		chk({high_gate_mode, low_gate_mode}, {HBG_G_HOLD, HBG_G_STRONG});
		// High-Z pin wins over PWM
		mcu_i.set_hiz(1);
		wait_gate(0, 0);
		mcu_i.set_pwm(0);
		repeat (8) @(negedge pclk);
		chk({high_gate_out, low_gate_out, high_gate_mode, low_gate_mode}, 32'h0000_0000);
		mcu_i.set_hiz(0);
		wait_gate(0, 1);
		// Register high-Z request
		apb(1, ADDR_CTRL, 32'h0000_0004);
		wait_gate(0, 0);
		apb(1, ADDR_CTRL, 32'h0000_0000);
		wait_gate(0, 1);
		// Register supplies the PWM level
		apb(1, ADDR_CTRL, 32'h0000_0003);
		wait_gate(1, 0);
		mcu_i.set_pwm(1);
		apb(1, ADDR_CTRL, 32'h0000_0001);
		wait_gate(0, 1);
		apb(1, ADDR_CTRL, 32'h0000_0000);
		wait_gate(1, 0);
		// Writes refused without select, and to the status word
		mcu_i.select(0);
		apb(1, ADDR_DRIVE, 32'h0000_0011);
		chk(err, 1);
		apb(0, ADDR_DRIVE, 32'h0000_0000);
		chk(rd, 32'h0000_005A);
		mcu_i.select(1);
		apb(1, ADDR_STATUS, 32'h0000_0000);
		chk(err, 1);
		// A new command cuts a long drive span short
		apb(1, ADDR_TIMING, 32'h0000_0240);
		mcu_i.set_pwm(0);
		n = 0;
		while (fault_blank !== 1'b1 && n < 60)
		begin
			@(negedge pclk);
			n++;
		end
		mcu_i.set_pwm(1);
		n = 0;
		while (fault_blank === 1'b1 && n < 60)
		begin
			@(negedge pclk);
			n++;
		end
		chk(n < 10, 1);
		wait_gate(1, 0);
		// Same on the high side
		mcu_i.set_pwm(0);
		n = 0;
		while (fault_blank === 1'b1 && n < 60)
		begin
			@(negedge pclk);
			n++;
		end
		chk(n < 10, 1);
		wait_gate(0, 1);
		// Hardware variant: latch at reset, ignore later pins, relatch on wake
		presetn <= 1'b0;
		hw_variant <= 1'b1;
		mcu_i.set_cfg(16'h1234);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(negedge pclk);
		chk({hw_active, gain_code, ocp_level_code, source_current_code, sink_current_code,
			mode_code}, 32'h0011_2334);
		mcu_i.set_cfg(16'h5678);
		repeat (8) @(negedge pclk);
		chk({hw_active, gain_code, ocp_level_code, source_current_code, sink_current_code,
			mode_code}, 32'h0011_2334);
		mcu_i.reconfigure(16'h9ABC);
		repeat (8) @(negedge pclk);
		chk({hw_active, gain_code, ocp_level_code, source_current_code, sink_current_code,
			mode_code}, 32'h0019_ABBC);
		give_verdict();
	end
endmodule
